// [sap_audio_port.sv]
// serializer side slave receiver and deserializer side master transmitter
module sap_audio_port import sap_pkg::*; #(
    parameter int LANES     = LANES_DEF,
    parameter int WORD_BITS = WORD_BITS_DEF,
    parameter int TX_BITS   = WORD_BITS_DEF,
    parameter int BCLK_HALF = BCLK_HALF_DEF,
    parameter int PCLK_KHZ  = PCLK_KHZ_DEF
) (
    // system
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST,
    // serializer side pins, all driven by the external master
    input  wire logic                       SER_BIT_CLOCK,
    input  wire logic                       SER_AUDIO_WORD_CLOCK,
    input  wire logic [LANES-1:0]           SER_AUDIO_DATA_LINE,
    // captured words
    output logic      [LANES*WORD_BITS-1:0] RX_WORD,
    output logic      [LEN_W-1:0]           RX_WORD_LEN,
    output logic                            RX_RIGHT,
    output logic                            RX_VALID,
    // transmit sample source
    input  wire logic                       TX_ENABLE,
    input  wire logic [LANES*TX_BITS-1:0]   TX_SAMPLE,
    output logic                            TX_SAMPLE_TAKEN,
    output logic                            TX_NEXT_RIGHT,
    // deserializer side master pins
    output logic                            DES_MASTER_CLOCK,
    output logic                            DES_BIT_CLOCK,
    output logic                            DES_AUDIO_WORD_CLOCK,
    output logic      [LANES-1:0]           DES_AUDIO_DATA_LINE
);
    localparam int TW = $clog2(TX_BITS);

    // our own bit clock must respect the limits the source side obeys
    if (SYS_CLK_KHZ / (2 * BCLK_HALF) > BCLK_MAX_KHZ ||
        SYS_CLK_KHZ / BCLK_HALF > PCLK_KHZ || BCLK_HALF < BCLK_HALF_MIN) begin : g_bad_rate
        $error("bit clock too fast for link limits");
    end
    if (WORD_BITS < 2 || WORD_BITS >= 255 || TX_BITS < 2 || LANES < 1) begin : g_bad_size
        $error("unsupported word width or lane count");
    end

    // receive side: slave to the external clocks
    logic [2:0]       s_bclk_ff;
    logic [1:0]       s_wc_ff;
    logic [LANES-1:0] s_d0_ff;
    logic [LANES-1:0] s_d1_ff;
    logic             rx_rise;
    logic             wc_last_ff;
    logic             seen_ff;
    logic [LEN_W-1:0] cnt_ff;
    logic [LEN_W-1:0] nxt_cnt;
    logic [WORD_BITS-1:0] rx_sh_ff  [LANES];
    logic [WORD_BITS-1:0] nxt_rx_sh [LANES];

    // two stages on every pin, three on the bit clock; stage 0 feeds only stage 1
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            s_bclk_ff <= '0;
            s_wc_ff   <= '0;
            s_d0_ff   <= '0;
            s_d1_ff   <= '0;
        end else begin
            s_bclk_ff <= {s_bclk_ff[1:0], SER_BIT_CLOCK};
            s_wc_ff   <= {s_wc_ff[0], SER_AUDIO_WORD_CLOCK};
            s_d0_ff   <= SER_AUDIO_DATA_LINE;
            s_d1_ff   <= s_d0_ff;
        end
    end

    // data is taken on the external bit clock rising edge
    assign rx_rise = s_bclk_ff[1] & ~s_bclk_ff[2];
    assign nxt_cnt = (cnt_ff == '1) ? cnt_ff : cnt_ff + LEN_W'(1);

    // msb first shift; bits past WORD_BITS are dropped, keeping the msbs
    for (genvar l = 0; l < LANES; l++) begin : g_rx_lane
        assign nxt_rx_sh[l] = (cnt_ff < LEN_W'(WORD_BITS)) ?
                              {rx_sh_ff[l][WORD_BITS-2:0], s_d1_ff[l]} : rx_sh_ff[l];
        always_ff @(posedge SYS_CLK) begin
            if (RST) begin
                rx_sh_ff[l] <= '0;
                RX_WORD[l*WORD_BITS +: WORD_BITS] <= '0;
            end else if (rx_rise) begin
                if (s_wc_ff[1] != wc_last_ff) begin
                    rx_sh_ff[l] <= '0;
                    if (seen_ff) begin
                        RX_WORD[l*WORD_BITS +: WORD_BITS] <= nxt_rx_sh[l];
                    end
                end else begin
                    rx_sh_ff[l] <= nxt_rx_sh[l];
                end
            end
        end
    end

    // a word clock change marks the last bit of the word, one before the next msb
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wc_last_ff  <= 1'b0;
            seen_ff     <= 1'b0;
            cnt_ff      <= '0;
            RX_WORD_LEN <= '0;
            RX_RIGHT    <= 1'b0;
            RX_VALID    <= 1'b0;
        end else begin
            RX_VALID <= 1'b0;
            if (rx_rise) begin
                if (s_wc_ff[1] != wc_last_ff) begin
                    wc_last_ff <= s_wc_ff[1];
                    seen_ff    <= 1'b1;
                    cnt_ff     <= '0;
                    if (seen_ff) begin
                        RX_WORD_LEN <= nxt_cnt;   // long halves still close on the turn
                        RX_RIGHT    <= wc_last_ff;
                        RX_VALID    <= 1'b1;
                    end
                end else begin
                    cnt_ff <= nxt_cnt;
                end
            end
        end
    end

    // transmit side: master of every bus clock
    sap_tx_e         tx_st_ff;
    logic            gen_mclk;
    logic            gen_bclk;
    logic            gen_fall;
    logic [TW-1:0]   bit_ff;
    logic [TW-1:0]   nxt_bit;
    logic            wc_ff;
    logic [LANES*TX_BITS-1:0] tx_sh_ff;

    sap_clk_gen #(
        .HALF    (BCLK_HALF)
    ) u_clk_gen (
        .clk     (SYS_CLK),
        .rst     (RST),
        .run     (tx_st_ff == SAP_TX_RUN),
        .mclk_ff (gen_mclk),
        .bclk_ff (gen_bclk),
        .fall_ff (gen_fall)
    );

    assign nxt_bit = (bit_ff == TW'(TX_BITS - 1)) ? '0 : bit_ff + TW'(1);

    // master clocks leave through one register each
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DES_MASTER_CLOCK <= PIN_RST_VAL;
            DES_BIT_CLOCK    <= PIN_RST_VAL;
        end else begin
            DES_MASTER_CLOCK <= gen_mclk;
            DES_BIT_CLOCK    <= gen_bclk;
        end
    end

    // frame sequencer; stops only before a left word so frames stay whole
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tx_st_ff             <= SAP_TX_IDLE;
            bit_ff               <= TW'(TX_BITS - 2);
            wc_ff                <= 1'b0;
            tx_sh_ff             <= '0;
            TX_SAMPLE_TAKEN      <= 1'b0;
            TX_NEXT_RIGHT        <= 1'b0;
            DES_AUDIO_WORD_CLOCK <= PIN_RST_VAL;
            DES_AUDIO_DATA_LINE  <= '0;
        end else begin
            TX_SAMPLE_TAKEN <= 1'b0;
            case (tx_st_ff)
                SAP_TX_IDLE: begin
                    bit_ff <= TW'(TX_BITS - 2);
                    wc_ff  <= 1'b0;
                    if (TX_ENABLE) begin
                        tx_st_ff <= SAP_TX_RUN;
                    end
                end
                SAP_TX_RUN: begin
                    if (gen_fall) begin
                        if (nxt_bit == '0 && !wc_ff && !TX_ENABLE) begin
                            tx_st_ff            <= SAP_TX_IDLE;
                            DES_AUDIO_DATA_LINE <= '0;
                        end else begin
                            bit_ff <= nxt_bit;
                            // word clock flips with the lsb, one bit before msb
                            if (nxt_bit == TW'(TX_BITS - 1)) begin
                                wc_ff                <= ~wc_ff;
                                DES_AUDIO_WORD_CLOCK <= ~wc_ff;
                                TX_NEXT_RIGHT        <= ~wc_ff;
                            end
                            if (nxt_bit == '0) begin
                                tx_sh_ff        <= TX_SAMPLE;
                                TX_SAMPLE_TAKEN <= 1'b1;
                            end
                            for (int l = 0; l < LANES; l++) begin
                                DES_AUDIO_DATA_LINE[l] <= (nxt_bit == '0) ?
                                    TX_SAMPLE[l*TX_BITS + TX_BITS - 1] :
                                    tx_sh_ff[l*TX_BITS + TX_BITS - 1 - int'(nxt_bit)];
                            end
                        end
                    end
                end
                default: tx_st_ff <= SAP_TX_IDLE;
            endcase
        end
    end

    // checks on the outputs and capture path
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    wc_lsb_align_a: assert property (
            $changed(DES_AUDIO_WORD_CLOCK) |-> bit_ff == TW'(TX_BITS - 1))
        else $error("word clock moved away from the lsb slot");
    msb_first_a: assert property (
            TX_SAMPLE_TAKEN |-> DES_AUDIO_DATA_LINE[0] == $past(TX_SAMPLE[TX_BITS-1]))
        else $error("first bit of a word is not its msb");
    data_on_fall_a: assert property (
            $changed(DES_AUDIO_DATA_LINE) && $past(tx_st_ff) == SAP_TX_RUN
            |-> $fell(DES_BIT_CLOCK))
        else $error("data changed off the bit clock falling edge");
    mclk_ratio_a: assert property ($rose(DES_BIT_CLOCK) |-> $fell(DES_MASTER_CLOCK))
        else $error("master clock out of step with bit clock");
    idle_quiet_a: assert property (
            tx_st_ff == SAP_TX_IDLE [*2] |-> !DES_BIT_CLOCK && !DES_AUDIO_WORD_CLOCK)
        else $error("clocks driven while idle");
    rx_len_a: assert property (
            RX_VALID |-> RX_WORD_LEN ==
                (($past(cnt_ff) == '1) ? '1 : $past(cnt_ff) + LEN_W'(1)))
        else $error("captured length does not match bit count");
    rx_chan_a: assert property (RX_VALID |-> RX_RIGHT != wc_last_ff && $past(rx_rise))
        else $error("captured channel does not match word clock");
    rx_pulse_a: assert property (RX_VALID |=> !RX_VALID ##1 !RX_VALID)
        else $error("capture pulse longer than one cycle");
endmodule

// [sap_pkg_clkgen.sv]
// Operation
// - bus is bit clock, word clock, data
// - master makes both clocks, others are slaves
// - transmitter drives data on master's clocks
// - serializer side is slave, takes clocks in
// - deserializer side is master, drives all clocks
// - two channels per line, word clock frames
// - msb first, word clock low means left
// - slave infers word length from word clock
package sap_pkg;
    // system clock rate and link limits
    localparam int SYS_CLK_KHZ   = 200000;
    localparam int BCLK_MAX_KHZ  = 12288;
    localparam int PCLK_KHZ_DEF  = 75000;
    // least bit clock half period in system cycles, rounded up
    localparam int BCLK_HALF_MIN = (SYS_CLK_KHZ + 2 * BCLK_MAX_KHZ - 1) / (2 * BCLK_MAX_KHZ);
    // default half period: 200 MHz / 64 gives about 3.1 MHz
    localparam int BCLK_HALF_DEF = 32;
    localparam int WORD_BITS_DEF = 32;
    localparam int LANES_DEF     = 4;
    localparam int LEN_W         = 8;
    // values after reset
    localparam logic PIN_RST_VAL = 1'b0;
    // transmit side states
    typedef enum logic [0:0] {
        SAP_TX_IDLE = 1'b0,
        SAP_TX_RUN  = 1'b1
    } sap_tx_e;
endpackage

// master clock and bit clock divider for the deserializer side
module sap_clk_gen import sap_pkg::*; #(
    parameter int HALF = BCLK_HALF_DEF
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // run gate
    input  wire logic run,
    // generated clocks
    output logic      mclk_ff,
    output logic      bclk_ff,
    output logic      fall_ff
);
    localparam int CW = $clog2(HALF);

    if (HALF < 2 || HALF % 2 != 0) begin : g_bad_half
        $error("bit clock half period must be even and at least 2");
    end

    logic [CW-1:0] cnt_ff;

    // master clock toggles twice per bit clock half, so it runs at 2x
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_ff  <= '0;
            mclk_ff <= PIN_RST_VAL;
            bclk_ff <= PIN_RST_VAL;
            fall_ff <= 1'b0;
        end else begin
            fall_ff <= 1'b0;
            if (cnt_ff == CW'(HALF - 1)) begin
                cnt_ff  <= '0;
                mclk_ff <= ~mclk_ff;
                bclk_ff <= ~bclk_ff;
                fall_ff <= bclk_ff;   // high going low
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
                if (cnt_ff == CW'(HALF / 2 - 1)) begin
                    mclk_ff <= ~mclk_ff;
                end
            end
        end
    end
endmodule

// [sap_far_end.sv]
// far side: an audio master feeding the serializer pins, a sink on the deserializer pins
module sap_far_end (
    // source pins toward the serializer side
    output logic             ser_bclk,
    output logic             ser_wclk,
    output logic [3:0]       ser_data,
    // sink pins from the deserializer side
    input  wire logic        des_bclk,
    input  wire logic        des_wclk,
    input  wire logic [3:0]  des_data,
    // last word the sink closed
    output logic [127:0]     snk_word,
    output logic [7:0]       snk_len,
    output logic             snk_right,
    output logic             snk_tgl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [127:0] shf;
    logic [7:0]   cnt;
    logic         wc_prev;
    logic         armed;
    // this side is master: both clocks stand low until a frame starts
    initial begin
        {ser_bclk, ser_wclk, ser_data} = '0;
        {snk_word, snk_len, snk_right, snk_tgl} = '0;
        {shf, cnt, wc_prev, armed} = '0;
    end
    // msb first; word clock turns with the lsb so the next msb trails it by one bit;
    // 125 ns bit period is 8 MHz, under both limits, rate is bits times words
    task automatic send_word(input logic right, input int len, input logic [255:0] v);
        for (int i = len - 1; i >= 0; i--) begin
            for (int l = 0; l < 4; l++) begin
                ser_data[l] = v[l*64+i];
            end
            ser_wclk = (i == 0) ? ~right : right;
            #60 ser_bclk = 1'b1;
            #65 ser_bclk = 1'b0;
        end
        ser_data = ~ser_data;  // a released line must not keep its last bit
    endtask
    // bit taken at bit clock rise; the bit where word clock turns closes the word;
    // the first turn only arms it, since the lead bit carries no word
    always @(posedge des_bclk) begin
        for (int l = 0; l < 4; l++) begin
            shf[l*32+:32] = {shf[l*32+:31], des_data[l]};
        end
        cnt = cnt + 8'h01;
        if (des_wclk !== wc_prev) begin
            if (armed) begin
                {snk_word, snk_len, snk_right} = {shf, cnt, wc_prev};
                snk_tgl = ~snk_tgl;
            end
            {shf, cnt, armed, wc_prev} = {128'h0, 8'h00, 1'b1, des_wclk};
        end
    end
endmodule

// [sap_audio_port_test.sv]
module sap_audio_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 10;  // short bit clock keeps the run brief
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         tx_enable = 1'b0;
    logic         tx_ch = 1'b1;
    logic         ser_bclk, ser_wclk, rx_right, rx_valid, tx_taken, tx_next_right;
    logic         des_mclk, des_bclk, des_wclk, snk_right, snk_tgl;
    logic [3:0]   ser_data, des_data;
    logic [7:0]   rx_len, snk_len;
    logic [127:0] rx_word, snk_word;
    logic [127:0] tx_sample = '0;
    logic [136:0] rx_q[$];
    logic [128:0] tx_q[$];
    int           n_errors = 0;
    int           n_tests = 0;
    int           cyc = 0;
    int           prev_rise = 0;
    int           takes = 0;
    int           mclk_rises = 0;

    always #2.5 sys_clk = ~sys_clk;

    sap_audio_port #(.BCLK_HALF(HALF)) sap_audio_port_i (
        .SYS_CLK(sys_clk), .RST(rst), .SER_BIT_CLOCK(ser_bclk),
        .SER_AUDIO_WORD_CLOCK(ser_wclk), .SER_AUDIO_DATA_LINE(ser_data),
        .RX_WORD(rx_word), .RX_WORD_LEN(rx_len), .RX_RIGHT(rx_right), .RX_VALID(rx_valid),
        .TX_ENABLE(tx_enable), .TX_SAMPLE(tx_sample), .TX_SAMPLE_TAKEN(tx_taken),
        .TX_NEXT_RIGHT(tx_next_right), .DES_MASTER_CLOCK(des_mclk),
        .DES_BIT_CLOCK(des_bclk), .DES_AUDIO_WORD_CLOCK(des_wclk),
        .DES_AUDIO_DATA_LINE(des_data));

    sap_far_end sap_far_end_i (
        .ser_bclk(ser_bclk), .ser_wclk(ser_wclk), .ser_data(ser_data),
        .des_bclk(des_bclk), .des_wclk(des_wclk), .des_data(des_data),
        .snk_word(snk_word), .snk_len(snk_len), .snk_right(snk_right), .snk_tgl(snk_tgl));

    task automatic note(input logic [136:0] got, input logic [136:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rx(input logic [136:0] got, input logic [136:0] exp);
        note(got, exp);
    endtask
    task automatic cmp_tx(input logic [128:0] got, input logic [128:0] exp);
        note(137'(got), 137'(exp));
    endtask
    task automatic cmp_clk(input logic [31:0] got, input logic [31:0] exp);
        note(137'(got), 137'(exp));
    endtask
    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // words of mixed length; longer than the capture keeps its msbs
    task automatic rx_run;
        int           lens[6] = '{24, 16, 32, 40, 2, 31};
        logic [255:0] v;
        logic [127:0] w;
        sap_far_end_i.send_word(1'b0, 8, '1);  // lead word is never reported
        foreach (lens[k]) begin
            for (int l = 0; l < 8; l++) v[l*32+:32] = $urandom;
            for (int l = 0; l < 4; l++) begin
                w[l*32+:32] = (lens[k] > 32) ? v[l*64+lens[k]-32+:32]
                                             : v[l*64+:32] & ~(32'hFFFF_FFFF << lens[k]);
            end
            rx_q.push_back({k % 2 == 0, 8'(lens[k]), w});
            sap_far_end_i.send_word(k % 2 == 0, lens[k], v);
        end
        repeat (50) @(negedge sys_clk);
        cmp_rx(137'(rx_q.size()), '0);
    endtask
    // run a few words, then drop enable at a random word and check the bus falls quiet
    task automatic tx_run;
        int stop_at;
        stop_at = 3 + ($urandom % 3);
        tx_enable = 1'b1;
        for (int t = 0; t < 6000 && takes < stop_at; t++) @(negedge sys_clk);
        tx_enable = 1'b0;
        repeat (3 * 64 * HALF) @(negedge sys_clk);
        cmp_clk(32'(tx_q.size()), 32'd0);
        cmp_clk(32'(takes), 32'(stop_at | 1));
        cmp_clk({29'd0, des_mclk, des_bclk, des_wclk}, 32'd0);
    endtask

    // reported receive words against the oldest one sent
    always @(negedge sys_clk) begin
        if (!rst && rx_valid === 1'b1) begin
            cmp_rx({rx_right, rx_len, rx_word}, rx_q.size() ? rx_q.pop_front() : 'x);
        end
    end
    // a take records the sample with the channel the model expects, right first
    always @(negedge sys_clk) begin
        if (tx_taken === 1'b1) begin
            cmp_clk(32'(tx_next_right), 32'(tx_ch));
            tx_q.push_back({tx_ch, tx_sample});
            tx_ch = ~tx_ch;
            takes++;
            tx_sample = {$urandom, $urandom, $urandom, $urandom};
        end
    end
    always @(snk_tgl) begin
        if (!rst) begin
            cmp_tx({snk_right, snk_word}, tx_q.size() ? tx_q.pop_front() : 'x);
            cmp_clk(32'(snk_len), 32'd32);
        end
    end
    // master clock runs at twice the bit clock: two rises per bit
    always @(posedge des_mclk) mclk_rises++;
    always @(posedge des_bclk) begin
        if (prev_rise != 0) cmp_clk(32'(cyc - prev_rise), 32'(2 * HALF));
        if (prev_rise != 0) cmp_clk(32'(mclk_rises), 32'd2);
        prev_rise = cyc;
        mclk_rises = 0;
    end
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h3D60));
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        fork
            rx_run();
            tx_run();
        join
        tally_and_finish();
    end
endmodule
